/* core/pd_sink_defines.svh */
// Offsets, reset values, field positions and timing figures of the
// sink register bank. Definitions only; included by bare name.
`ifndef PD_SINK_DEFINES_SVH
`define PD_SINK_DEFINES_SVH

// Byte addresses reached through the command byte
`define ADDR_STATUS 8'h1D
`define ADDR_HOTSPOT 8'h22
`define ADDR_OC_LIMIT 8'h23
`define ADDR_OH_LIMIT 8'h24
`define ADDR_DERATE 8'h25
`define ADDR_NTC25 8'h28
`define ADDR_NTC50 8'h2A
`define ADDR_NTC75 8'h2C
`define ADDR_NTC100 8'h2E
`define ADDR_REQUEST 8'h30

// Reset values
`define RST_HOTSPOT 8'h19
`define RST_OC_LIMIT 8'h00
`define RST_OH_LIMIT 8'h78
`define RST_DERATE 8'h78
`define RST_NTC25 16'h2710
`define RST_NTC50 16'h1041
`define RST_NTC75 16'h0788
`define RST_NTC100 16'h03CE

// Status bits and request object layout
`define STAT_READY 0
`define STAT_SUCCESS 1
`define REQ_BYTES 3'h4
`define REQ_RSV_TOP 31
`define REQ_POS_MSB 30
`define REQ_POS_LSB 28
`define REQ_RSV_MSB 27
`define REQ_RSV_LSB 20
`define REQ_PPS_RSV_MSB 8
`define REQ_PPS_RSV_LSB 7

// Slave address; arbitrary value
`define I2C_ADDR 7'h51

// Timing: clock rate, LED periods and keep-alive interval in ms
`define CLK_HZ 200000000
`define MS_CYCLES (`CLK_HZ / 1000)
`define LED_BREATH_MS 4000
`define LED_LEGACY_MS 2000
`define LED_FAULT_MS 600
`define KEEPALIVE_MS 8000

`endif

/* core/pd_sink_pkg.sv */
// Types shared by the sink register bank and its serial slave.
// Assumes the defines header is compiled alongside.
package pd_sink_pkg;

    typedef enum logic [6:0] {
        I_IDLE = 7'h01,
        I_ADDR = 7'h02,
        I_ACKA = 7'h04,
        I_WR = 7'h08,
        I_ACKW = 7'h10,
        I_RD = 7'h20,
        I_ACKR = 7'h40
    } i2c_state_t;

    typedef enum logic [4:0] {
        L_INIT = 5'h01,
        L_CHARGING = 5'h02,
        L_LIGHT_LOAD = 5'h04,
        L_LEGACY = 5'h08,
        L_FAULT = 5'h10
    } led_state_t;

    typedef struct packed {
        logic start;
        logic stop;
        logic wr;
        logic first;
        logic rd;
        logic [7:0] data;
    } i2c_ev_t;

    typedef struct packed {
        logic [7:0] overcurrent_limit;
        logic [7:0] overheat_limit;
        logic [7:0] derate_limit;
        logic [15:0] ntc_ohms_25c;
        logic [15:0] ntc_ohms_50c;
        logic [15:0] ntc_ohms_75c;
        logic [15:0] ntc_ohms_100c;
    } limits_t;

    typedef struct packed {
        i2c_state_t st;
        logic scl_p;
        logic sda_p;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic rw;
        logic acked;
        logic first;
        logic sda_oe;
        i2c_ev_t ev;
    } slave_t;

    typedef struct packed {
        led_state_t led;
        logic [7:0] ptr;
        logic [7:0] hotspot;
        limits_t lim;
        logic [31:0] req_shadow;
        logic [2:0] req_cnt;
        logic [31:0] req;
        logic ready;
        logic success;
        logic neg_start;
        logic hard_reset;
        logic out_en;
        logic pps_pending;
        logic pps_mode;
        logic led_pin;
        logic sda_o;
        logic [31:0] div;
        logic [12:0] ms;
        logic [10:0] pwm;
        logic [13:0] keep;
    } bank_t;

endpackage

/* core/i2c_byte_slave.sv */
// Byte-level serial slave: start/stop detection, address match,
// write bytes out as events, read bytes loaded from rd_data.
// Assumes scl_i and sda_i are already synchronous to clk.
`timescale 1ns/100ps
`include "pd_sink_defines.svh"

module i2c_byte_slave #(
    parameter logic [6:0] DEV_ADDR = `I2C_ADDR
) (
    input wire logic clk, // System clock
    input wire logic sys_rst, // Async reset, high
    input wire logic scl_i, // Serial clock level
    input wire logic sda_i, // Serial data level
    input wire logic [7:0] rd_data, // Byte at current pointer
    output logic sda_oe, // Pull data low while high
    output pd_sink_pkg::i2c_ev_t ev // Byte events, one-cycle pulses
);
    pd_sink_pkg::slave_t q, q_d;
    logic rise, fall;

    assign sda_oe = q.sda_oe;
    assign ev = q.ev;

    always_comb begin
        q_d = q;
        q_d.ev = '0;
        q_d.scl_p = scl_i;
        q_d.sda_p = sda_i;
        rise = scl_i & ~q.scl_p;
        fall = ~scl_i & q.scl_p;
        if (q.scl_p && scl_i && q.sda_p && !sda_i) begin
            q_d.st = pd_sink_pkg::I_ADDR;
            q_d.cnt = 4'h0;
            q_d.sda_oe = 1'b0;
            q_d.first = 1'b1;
            q_d.ev.start = 1'b1;
        end else if (q.scl_p && scl_i && !q.sda_p && sda_i) begin
            q_d.st = pd_sink_pkg::I_IDLE;
            q_d.sda_oe = 1'b0;
            q_d.ev.stop = (q.st != pd_sink_pkg::I_IDLE);
        end else if (rise) begin
            if ((q.st == pd_sink_pkg::I_ADDR || q.st == pd_sink_pkg::I_WR) && q.cnt < 4'h8) begin
                q_d.sh = {q.sh[6:0], sda_i};
                q_d.cnt = q.cnt + 4'h1;
            end
            if (q.st == pd_sink_pkg::I_RD) begin
                q_d.cnt = q.cnt + 4'h1;
            end
            if (q.st == pd_sink_pkg::I_ACKR) begin
                q_d.acked = ~sda_i;
            end
        end else if (fall) begin
            unique case (q.st)
                pd_sink_pkg::I_IDLE: begin
                end
                pd_sink_pkg::I_ADDR: begin
                    if (q.cnt == 4'h8) begin
                        if (q.sh[7:1] == DEV_ADDR) begin
                            q_d.st = pd_sink_pkg::I_ACKA;
                            q_d.sda_oe = 1'b1;
                            q_d.rw = q.sh[0];
                        end else begin
                            q_d.st = pd_sink_pkg::I_IDLE;
                        end
                    end
                end
                pd_sink_pkg::I_ACKA, pd_sink_pkg::I_ACKR: begin
                    if (q.st == pd_sink_pkg::I_ACKR && !q.acked) begin
                        // Master gave no ack: last byte of the read
                        q_d.st = pd_sink_pkg::I_IDLE;
                    end else if (q.rw) begin
                        q_d.sh = rd_data;
                        q_d.ev.rd = 1'b1;
                        q_d.st = pd_sink_pkg::I_RD;
                        q_d.cnt = 4'h0;
                        q_d.sda_oe = ~rd_data[7];
                    end else begin
                        q_d.st = pd_sink_pkg::I_WR;
                        q_d.cnt = 4'h0;
                        q_d.sda_oe = 1'b0;
                    end
                end
                pd_sink_pkg::I_WR: begin
                    if (q.cnt == 4'h8) begin
                        q_d.ev.wr = 1'b1;
                        q_d.ev.data = q.sh;
                        q_d.ev.first = q.first;
                        q_d.first = 1'b0;
                        q_d.sda_oe = 1'b1;
                        q_d.st = pd_sink_pkg::I_ACKW;
                    end
                end
                pd_sink_pkg::I_ACKW: begin
                    q_d.sda_oe = 1'b0;
                    q_d.st = pd_sink_pkg::I_WR;
                    q_d.cnt = 4'h0;
                end
                pd_sink_pkg::I_RD: begin
                    if (q.cnt == 4'h8) begin
                        q_d.sda_oe = 1'b0;
                        q_d.st = pd_sink_pkg::I_ACKR;
                    end else begin
                        q_d.sh = {q.sh[6:0], 1'b0};
                        q_d.sda_oe = ~q.sh[6];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '{st: pd_sink_pkg::I_IDLE, scl_p: 1'b1, sda_p: 1'b1, cnt: 4'h0,
                   sh: 8'h00, rw: 1'b0, acked: 1'b0, first: 1'b0, sda_oe: 1'b0,
                   ev: '0};
        end else begin
            q <= q_d;
        end
    end

endmodule

/* core/pd_sink_i2c_register_bank.sv */
// Serial-reachable register bank of a PD sink controller: limits,
// thermistor calibration, request object, status and LED indication.
// Assumes a negotiation engine, protection logic and a temperature
// estimator outside, all synchronous to clk.
//
// Function
// - Hotspot temperature register, resets to 25 degrees
// - Overcurrent limit register, 50 mA per step
// - Overcurrent limit takes negotiated maximum current while still zero
// - Overheat limit register, resets to 120 degrees
// - Derating limit register, resets to 120 degrees
// - Thermistor ohms at 25 and 50 degrees
// - Thermistor ohms at 75 and 100 degrees
// - Two-byte read, low byte first, last unacked
// - Request object written as four bytes, low first
// - Complete request object starts a negotiation
// - Accepted request sets success and ready
// - Rejected request clears success, sets ready
// - Programmable request enters self-renewing supply mode
// - All-zero request sends hard reset
// - Hard reset restores defaults, output off; an accept in the same cycle turns it back on
// - Output switches only after successful negotiation
// - LED off, breathing, or solid by state
// - LED flicker for legacy source or fault
// - Reading status clears it
`timescale 1ns/100ps
`include "pd_sink_defines.svh"

module pd_sink_i2c_register_bank #(
    parameter logic [6:0] DEV_ADDR = `I2C_ADDR,
    parameter int unsigned MS_CYCLES = `MS_CYCLES,
    parameter int unsigned KEEPALIVE_MS = `KEEPALIVE_MS
) (
    input wire logic clk, // System clock, 200 MHz
    input wire logic sys_rst, // Async reset, high
    input wire logic scl_i, // Serial clock level
    input wire logic sda_i, // Serial data level
    output logic sda_o, // Data driven value, always low
    output logic sda_oe, // Data pulled low while high
    input wire logic temp_update, // New hotspot estimate strobe
    input wire logic [7:0] temp_value, // Hotspot estimate, degrees
    input wire logic pdo_is_pps, // Selected object is programmable
    input wire logic [7:0] pdo_max_current, // Selected max current, 50 mA
    input wire logic neg_ok, // Source accepted request strobe
    input wire logic neg_rejected, // Source rejected request strobe
    input wire logic fault_event, // Protection tripped strobe
    input wire logic legacy_source, // Source not PD capable
    input wire logic current_low, // Charging current under 500 mA
    output logic [31:0] request_object, // Request to negotiate
    output logic negotiate_start, // One-cycle negotiation start
    output logic hard_reset_req, // One-cycle hard reset request
    output logic switched_output, // Output enable switch
    output logic pps_mode, // Programmable supply mode
    output logic led_drive_pin, // LED drive
    output pd_sink_pkg::limits_t limits // Thresholds and calibration
);
    pd_sink_pkg::bank_t q, q_d;
    pd_sink_pkg::i2c_ev_t ev;
    logic [7:0] rd_data;
    logic tick;
    logic [12:0] level;
    logic pps_ok;

    localparam logic [12:0] BREATH_MS = 13'(`LED_BREATH_MS);
    localparam logic [12:0] LEGACY_MS = 13'(`LED_LEGACY_MS);
    localparam logic [12:0] FAULT_MS = 13'(`LED_FAULT_MS);
    localparam logic [10:0] PWM_STEPS = 11'(`LED_BREATH_MS / 2);

    function automatic pd_sink_pkg::bank_t defaults();
        pd_sink_pkg::bank_t b;
        b = '0;
        b.led = pd_sink_pkg::L_INIT;
        b.hotspot = `RST_HOTSPOT;
        b.lim.overcurrent_limit = `RST_OC_LIMIT;
        b.lim.overheat_limit = `RST_OH_LIMIT;
        b.lim.derate_limit = `RST_DERATE;
        b.lim.ntc_ohms_25c = `RST_NTC25;
        b.lim.ntc_ohms_50c = `RST_NTC50;
        b.lim.ntc_ohms_75c = `RST_NTC75;
        b.lim.ntc_ohms_100c = `RST_NTC100;
        return b;
    endfunction

    function automatic logic in_request(input logic [7:0] a);
        return a[7:2] == 6'(`ADDR_REQUEST >> 2);
    endfunction

    function automatic logic [12:0] led_period(input pd_sink_pkg::led_state_t s);
        unique case (s)
            pd_sink_pkg::L_LEGACY: return LEGACY_MS;
            pd_sink_pkg::L_FAULT: return FAULT_MS;
            pd_sink_pkg::L_INIT, pd_sink_pkg::L_CHARGING,
            pd_sink_pkg::L_LIGHT_LOAD: return BREATH_MS;
        endcase
    endfunction

    i2c_byte_slave #(
        .DEV_ADDR(DEV_ADDR)
    ) u_slave (
        .clk(clk),
        .sys_rst(sys_rst),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .rd_data(rd_data),
        .sda_oe(sda_oe),
        .ev(ev)
    );

    assign sda_o = q.sda_o;
    assign request_object = q.req;
    assign negotiate_start = q.neg_start;
    assign hard_reset_req = q.hard_reset;
    assign switched_output = q.out_en;
    assign pps_mode = q.pps_mode;
    assign led_drive_pin = q.led_pin;
    assign limits = q.lim;

    // byte at pointer, 16-bit words low byte first
    always_comb begin
        unique case (q.ptr)
            `ADDR_STATUS: rd_data = {6'h00, q.success, q.ready};
            `ADDR_HOTSPOT: rd_data = q.hotspot;
            `ADDR_OC_LIMIT: rd_data = q.lim.overcurrent_limit;
            `ADDR_OH_LIMIT: rd_data = q.lim.overheat_limit;
            `ADDR_DERATE: rd_data = q.lim.derate_limit;
            8'h28: rd_data = q.lim.ntc_ohms_25c[7:0];
            8'h29: rd_data = q.lim.ntc_ohms_25c[15:8];
            8'h2A: rd_data = q.lim.ntc_ohms_50c[7:0];
            8'h2B: rd_data = q.lim.ntc_ohms_50c[15:8];
            8'h2C: rd_data = q.lim.ntc_ohms_75c[7:0];
            8'h2D: rd_data = q.lim.ntc_ohms_75c[15:8];
            8'h2E: rd_data = q.lim.ntc_ohms_100c[7:0];
            8'h2F: rd_data = q.lim.ntc_ohms_100c[15:8];
            // Request object is write-only
            default: rd_data = 8'h00;
        endcase
    end

    always_comb begin
        q_d = q;
        q_d.neg_start = 1'b0;
        q_d.hard_reset = 1'b0;
        q_d.sda_o = 1'b0;
        tick = 1'b0;
        level = 13'h0000;
        pps_ok = 1'b0;

        // estimate tracked from the sensor path
        if (temp_update) begin
            q_d.hotspot = temp_value;
        end

        // read of status clears both bits
        if (ev.rd) begin
            if (q.ptr == `ADDR_STATUS) begin
                q_d.ready = 1'b0;
                q_d.success = 1'b0;
            end
            q_d.ptr = q.ptr + 8'h01;
        end

        if (ev.start) begin
            q_d.req_cnt = 3'h0;
        end

        if (ev.wr) begin
            if (ev.first) begin
                q_d.ptr = ev.data;
                q_d.req_cnt = 3'h0;
            end else begin
                // limits and calibration written byte by byte at the pointer
                unique case (q.ptr)
                    `ADDR_OC_LIMIT: q_d.lim.overcurrent_limit = ev.data;
                    `ADDR_OH_LIMIT: q_d.lim.overheat_limit = ev.data;
                    `ADDR_DERATE: q_d.lim.derate_limit = ev.data;
                    8'h28: q_d.lim.ntc_ohms_25c[7:0] = ev.data;
                    8'h29: q_d.lim.ntc_ohms_25c[15:8] = ev.data;
                    8'h2A: q_d.lim.ntc_ohms_50c[7:0] = ev.data;
                    8'h2B: q_d.lim.ntc_ohms_50c[15:8] = ev.data;
                    8'h2C: q_d.lim.ntc_ohms_75c[7:0] = ev.data;
                    8'h2D: q_d.lim.ntc_ohms_75c[15:8] = ev.data;
                    8'h2E: q_d.lim.ntc_ohms_100c[7:0] = ev.data;
                    8'h2F: q_d.lim.ntc_ohms_100c[15:8] = ev.data;
                    default: begin
                    end
                endcase
                // bytes land low first by address
                if (in_request(q.ptr)) begin
                    q_d.req_shadow[q.ptr[1:0] * 8 +: 8] = ev.data;
                    if (q.req_cnt != `REQ_BYTES) begin
                        q_d.req_cnt = q.req_cnt + 3'h1;
                    end
                end
                q_d.ptr = q.ptr + 8'h01;
            end
        end

        // only a full four-byte write counts, at stop
        if (ev.stop && q.req_cnt == `REQ_BYTES) begin
            q_d.req_cnt = 3'h0;
            if (q.req_shadow == 32'h0000_0000) begin
                // all-zero object is the reset command
                // everything back to defaults, switch off; a neg_ok in the same cycle turns it back on
                q_d = defaults();
                q_d.hard_reset = 1'b1;
            end else begin
                pps_ok = pdo_is_pps && !q.req_shadow[`REQ_RSV_TOP]
                    && q.req_shadow[`REQ_POS_MSB:`REQ_POS_LSB] != 3'h0
                    && q.req_shadow[`REQ_RSV_MSB:`REQ_RSV_LSB] == 8'h00
                    && q.req_shadow[`REQ_PPS_RSV_MSB:`REQ_PPS_RSV_LSB] == 2'h0;
                q_d.req = q.req_shadow;
                q_d.neg_start = 1'b1;
                q_d.pps_pending = pps_ok;
                q_d.keep = 14'h0000;
            end
        end else if (ev.stop) begin
            q_d.req_cnt = 3'h0;
        end

        // Set wins over a read clear in the same cycle
        if (neg_ok) begin
            q_d.ready = 1'b1;
            q_d.success = 1'b1;
            q_d.out_en = 1'b1;
            q_d.pps_mode = q.pps_pending;
            q_d.keep = 14'h0000;
            // negotiated maximum, unless host set a limit
            if (q.lim.overcurrent_limit == 8'h00) begin
                q_d.lim.overcurrent_limit = pdo_max_current;
            end
            q_d.led = current_low ? pd_sink_pkg::L_LIGHT_LOAD : pd_sink_pkg::L_CHARGING;
        end else if (neg_rejected) begin
            // valid but failed, output left as it was
            q_d.ready = 1'b1;
            q_d.success = 1'b0;
        end

        // protection trip holds fault until next success or hard reset
        if (fault_event && !q_d.hard_reset) begin
            q_d.out_en = 1'b0;
            q_d.pps_mode = 1'b0;
            q_d.led = pd_sink_pkg::L_FAULT;
        end

        // charging vs light load, output stays on
        if (q_d.led == pd_sink_pkg::L_CHARGING && current_low) begin
            q_d.led = pd_sink_pkg::L_LIGHT_LOAD;
        end else if (q_d.led == pd_sink_pkg::L_LIGHT_LOAD && !current_low) begin
            q_d.led = pd_sink_pkg::L_CHARGING;
        end
        // legacy source seen while still initialising
        if (q_d.led == pd_sink_pkg::L_INIT && legacy_source) begin
            q_d.led = pd_sink_pkg::L_LEGACY;
            q_d.out_en = 1'b0;
        end

        // Millisecond time base shared by LED and keep-alive
        if (q.div >= MS_CYCLES - 1) begin
            q_d.div = 32'h0000_0000;
            tick = 1'b1;
        end else begin
            q_d.div = q.div + 32'h0000_0001;
        end

        // resend the request before the source gives up
        if (q_d.pps_mode && tick) begin
            if (q.keep >= 14'(KEEPALIVE_MS - 1)) begin
                q_d.keep = 14'h0000;
                q_d.neg_start = 1'b1;
            end else begin
                q_d.keep = q.keep + 14'h0001;
            end
        end

        // Pattern restarts from its start on any state change
        if (q_d.led != q.led) begin
            q_d.ms = 13'h0000;
        end else if (tick) begin
            q_d.ms = (q.ms >= led_period(q.led) - 13'h0001) ? 13'h0000 : q.ms + 13'h0001;
        end
        // Breathing PWM: 2000-step ramp, 10 us frame is well above flicker
        q_d.pwm = (q.pwm >= PWM_STEPS - 11'h001) ? 11'h000 : q.pwm + 11'h001;
        level = (q.ms < BREATH_MS / 2) ? q.ms : BREATH_MS - q.ms;

        unique case (q.led)
            pd_sink_pkg::L_INIT: q_d.led_pin = 1'b0;
            pd_sink_pkg::L_CHARGING: q_d.led_pin = {2'b00, q.pwm} < level;
            pd_sink_pkg::L_LIGHT_LOAD: q_d.led_pin = 1'b1;
            pd_sink_pkg::L_LEGACY: q_d.led_pin = q.ms < LEGACY_MS / 2;
            pd_sink_pkg::L_FAULT: q_d.led_pin = q.ms < FAULT_MS / 2;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= defaults();
        end else begin
            q <= q_d;
        end
    end

endmodule

/* dv/pd_sink_host_model.sv */
// Serial host model: drives clock and data, reads the wire.
// Assumes a pull-up on data and the bank pulling low via sda_oe.
`timescale 1ns/100ps
module pd_sink_host_model (
    input wire logic clk, // System clock
    input wire logic sda_oe, // Bank pulls data low
    output logic scl, // Serial clock
    output logic sda // Data wire level
);
    logic sda_m = 1'h1;
    initial scl = 1'h1;
    // Pull-up: a released line reads high
    assign sda = sda_m & ~sda_oe;
    // Four clocks a phase, above the three-clock minimum
    task automatic hold(input logic c, input logic d);
        @(negedge clk);
        scl = c;
        sda_m = d;
        repeat (3) @(negedge clk);
    endtask
    // data moves only while clock is low
    task automatic bit_out(input logic b);
        hold(1'h0, sda_m);
        hold(1'h0, b);
        hold(1'h1, b);
    endtask
    task automatic start();
        bit_out(1'h1);
        hold(1'h1, 1'h0);
    endtask
    task automatic stop();
        bit_out(1'h0);
        hold(1'h1, 1'h1);
    endtask
    task automatic xfer(input logic [7:0] w, input logic ma, output logic [7:0] r,
                        output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_out(w[i]);
            r[i] = sda;
        end
        bit_out(ma);
        ack = ~sda;
    endtask
endmodule

/* dv/pd_sink_bank_checker.sv */
// Port checker for the sink register bank.
// Assumes one clock domain with async active-high reset.
`timescale 1ns/100ps
`include "pd_sink_defines.svh"
module pd_sink_bank_checker #(
    parameter int unsigned MS_CYCLES = 10,
    parameter int unsigned KEEPALIVE_MS = 5
) (
    input wire logic clk, // Clock
    input wire logic sys_rst, // Reset
    input wire logic neg_ok, // Accepted
    input wire logic neg_rejected, // Rejected
    input wire logic fault_event, // Trip
    input wire logic [7:0] pdo_max_current, // Max current
    input wire logic negotiate_start, // Start pulse
    input wire logic hard_reset_req, // Hard reset
    input wire logic switched_output, // Output
    input wire logic pps_mode, // Programmable mode
    input wire logic led_drive_pin, // LED
    input wire logic [31:0] request_object, // Request
    input wire pd_sink_pkg::limits_t limits // Limits
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // Two cycles of slack for the start pipeline
    localparam int KA = KEEPALIVE_MS * MS_CYCLES + 2;
    int gap_q;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            gap_q <= 0;
        else
            gap_q <= (!pps_mode || negotiate_start) ? 0 : gap_q + 1;
    end
    a_out_on: assert property (neg_ok && !fault_event |=> switched_output)
        else $error("output off after accept");
    a_rej_hold: assert property (neg_rejected && !neg_ok |=> $stable(switched_output))
        else $error("output moved on reject");
    a_fault_off: assert property (fault_event |=> !switched_output && !pps_mode)
        else $error("output on after fault");
    a_start_once: assert property (negotiate_start |=> !negotiate_start)
        else $error("start pulse too long");
    a_hard_dflt: assert property (hard_reset_req |-> !switched_output &&
        request_object == 32'h0 && limits == {`RST_OC_LIMIT, `RST_OH_LIMIT, `RST_DERATE,
        `RST_NTC25, `RST_NTC50, `RST_NTC75, `RST_NTC100})
        else $error("defaults not restored");
    a_init_led: assert property (hard_reset_req |=> ##1 !led_drive_pin)
        else $error("led lit after reset");
    a_keep_alive: assert property (gap_q <= KA)
        else $error("keep-alive late");
    a_oc_load: assert property (neg_ok && limits.overcurrent_limit == 8'h00 |=>
        limits.overcurrent_limit == $past(pdo_max_current))
        else $error("limit not loaded");
endmodule

/* dv/pd_sink_i2c_register_bank_bench.sv */
// Bench for the sink register bank with a serial host model.
// Assumes the host model and checker are compiled alongside.
`timescale 1ns/100ps
`include "pd_sink_defines.svh"
module pd_sink_i2c_register_bank_bench;
    logic clk = 1'h0, sys_rst = 1'h1, temp_update = 1'h0, pdo_is_pps = 1'h0;
    logic neg_ok = 1'h0, neg_rejected = 1'h0, fault_event = 1'h0;
    logic legacy_source = 1'h0, current_low = 1'h0;
    logic [7:0] temp_value = 8'h00, pdo_max_current = 8'h00;
    logic scl, sda, sda_o, sda_oe, negotiate_start, hard_reset_req;
    logic switched_output, pps_mode, led_drive_pin;
    logic [31:0] request_object, v, rq;
    pd_sink_pkg::limits_t limits;
    int fail_count = 0, checks_done = 0, seed = 7, starts = 0, s, m[8];
    logic [7:0] ad[8] = '{8'h22, 8'h23, 8'h24, 8'h25, 8'h28, 8'h2A, 8'h2C, 8'h2E};
    always #2.5 clk = ~clk;
    always @(posedge clk) if (negotiate_start === 1'h1) starts++;
    pd_sink_i2c_register_bank #(.MS_CYCLES(10), .KEEPALIVE_MS(5)) dut_u (.clk, .sys_rst,
        .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe, .temp_update, .temp_value, .pdo_is_pps,
        .pdo_max_current, .neg_ok, .neg_rejected, .fault_event, .legacy_source,
        .current_low, .request_object, .negotiate_start, .hard_reset_req,
        .switched_output, .pps_mode, .led_drive_pin, .limits);
    pd_sink_host_model host_u (.clk, .sda_oe, .scl, .sda);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic [7:0] w);
        logic [7:0] r;
        logic a;
        host_u.xfer(w, 1'h1, r, a);
        chk(a, 1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input int n);
        host_u.start();
        wb({`I2C_ADDR, 1'h0});
        wb(a);
        for (int i = 0; i < n; i++) wb(d[8*i +: 8]);
        host_u.stop();
        repeat (3) @(negedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input int n);
        logic [7:0] r;
        logic k;
        v = 0;
        host_u.start();
        wb({`I2C_ADDR, 1'h0});
        wb(a);
        host_u.start();
        wb({`I2C_ADDR, 1'h1});
        for (int i = 0; i < n; i++) begin
            host_u.xfer(8'hFF, i == n - 1, r, k);
            v[8*i +: 8] = r;
        end
        host_u.stop();
    endtask
    task automatic st(input int e);
        rd(8'h1D, 1);
        chk(v, e);
    endtask
    task automatic pulse(ref logic p);
        @(negedge clk);
        p = 1'h1;
        @(negedge clk);
        p = 1'h0;
        @(negedge clk);
    endtask
    task automatic sweep();
        for (int i = 0; i < 8; i++) begin
            rd(ad[i], i < 4 ? 1 : 2);
            chk(v, m[i]);
        end
    endtask
    task automatic rs();
        m = '{`RST_HOTSPOT, `RST_OC_LIMIT, `RST_OH_LIMIT, `RST_DERATE, `RST_NTC25,
              `RST_NTC50, `RST_NTC75, `RST_NTC100};
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #400us;
        fail_count++;
        results();
    end
    initial begin
        rs();
        repeat (10) @(negedge clk);
        sys_rst = 1'h0;
        repeat (2) @(negedge clk);
        sweep();
        rq = {1'h0, 3'h1, 8'h00, 10'h12C, 10'h0C8};
        wr(8'h30, rq, 4);
        chk(starts, 1);
        chk(request_object, rq);
        pdo_max_current = 8'($random(seed));
        pulse(neg_ok);
        m[1] = pdo_max_current;
        st(3);
        st(0);
        chk({switched_output, pps_mode}, 2);
        wr(8'h30, rq, 4);
        pulse(neg_rejected);
        st(1);
        chk(switched_output, 1);
        wr(8'h30, rq, 3);
        chk(starts, 2);
        for (int i = 0; i < 8; i++) begin
            v = $random(seed);
            wr(ad[i], v, i < 4 ? 1 : 2);
            if (i > 0) m[i] = i < 4 ? v[7:0] : v[15:0];
        end
        temp_value = 8'($random(seed));
        pulse(temp_update);
        m[0] = temp_value;
        sweep();
        pdo_is_pps = 1'h1;
        rq = {1'h0, 3'h2, 8'h00, 11'h1F4, 2'h0, 7'h3C};
        wr(8'h30, rq, 4);
        pulse(neg_ok);
        chk(pps_mode, 1);
        current_low = 1'h1;
        s = starts;
        repeat (60) @(negedge clk);
        chk({starts > s, led_drive_pin}, 3);
        pulse(fault_event);
        chk({switched_output, pps_mode, led_drive_pin}, 1);
        wr(8'h30, 32'h0, 4);
        rs();
        chk({switched_output, sda_o}, 0);
        sweep();
        legacy_source = 1'h1;
        repeat (3) @(negedge clk);
        chk({switched_output, led_drive_pin}, 1);
        results();
    end
endmodule
bind pd_sink_i2c_register_bank pd_sink_bank_checker #(.MS_CYCLES(MS_CYCLES),
    .KEEPALIVE_MS(KEEPALIVE_MS)) chk_u (.clk, .sys_rst, .neg_ok, .neg_rejected,
    .fault_event, .pdo_max_current, .negotiate_start, .hard_reset_req, .switched_output,
    .pps_mode, .led_drive_pin, .request_object, .limits);
